// ### logic/edge_sync.sv
// Purpose: Three-stage synchroniser with rising edge detect
// Assumes: Input is asynchronous to ref_clk
// Notes:   A change counts once stages two and three agree
`timescale 1ns/1ps
module edge_sync (
  input  wire logic ref_clk,
  input  wire logic rst_n,
  input  wire logic async_in,
  output logic      level_out,
  output logic      rise_out
);
  logic s1_r;
  logic s2_r;
  logic s3_r;
  logic lvl_r;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
    end else begin
      s1_r <= async_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // Level only moves when the last two stages agree, filtering a metastable sample
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      lvl_r <= 1'b0;
    end else if (s2_r == s3_r) begin
      lvl_r <= s3_r;
    end
  end

  assign level_out = lvl_r;
  assign rise_out  = (s2_r == s3_r) && s3_r && !lvl_r;
endmodule

// ### logic/rdburst_engine.sv
// Purpose: Read burst length choice and output drive window of the memory device
// Assumes: Commands sampled on the link clock rising edge seen through a synchroniser
// Notes:   Strobe is modelled as a drive window plus toggle, data as column beats
//
// How it works
// R1: A12 low gives chopped 4-beat burst, high gives 8-beat burst per command.
// R2: A12 selects length only; it never forms part of the column address.
// R3: Mode field 00 fixed 8, 10 fixed 4, 01 lets A12 choose.
// R4: Controller spaces precharge after read by additive latency plus tRTP.
// R5: Controller uses tRTP of at least four cycles and 7.5 ns.
// R6: Controller also keeps activate-to-precharge interval when precharging after read.
// R7: Controller activates again only after tRP and tRC have elapsed.
// R8: Drive stops at edge RL plus four for 8 beats, plus two for chop.
// R9: Controller resets and reinitialises after general timing violations.
// R10: Bad write data timing may corrupt that location; device never hangs.
// R11: Bad write strobe timing may corrupt only that write; device never hangs.
// R12: Controller meets timing on every strobe edge of every write burst.
// R13: Read data starts read latency after READ, latency being AL plus CL.
// R14: Controller precharges before new row and activates before access.
// R15: Controller tracks per-bank interval counters before issuing commands.
// R16: In fixed modes A12 is ignored and the mode length applies.
`timescale 1ns/1ps
module rdburst_engine #(
  parameter int DQ_W  = rdburst_pkg::DQ_W,
  parameter int LAT_W = 6
) (
  input  wire logic                   ref_clk,
  input  wire logic                   rst_n,
  input  wire logic                   link_clk,
  input  wire rdburst_pkg::cmd_pkt_t  cmd_in,
  input  wire logic [DQ_W-1:0]        rd_word,
  output logic                        dq_oe,
  output logic [DQ_W-1:0]             dq_out,
  output logic                        dqs_oe,
  output logic                        dqs_out,
  output logic [9:0]                  col_out,
  output logic                        col_valid,
  output logic                        chop_out,
  output logic [1:0]                  bl_mode_out
);
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_WAIT = 2'h1,
    ST_BURST = 2'h2
  } st_t;

  logic                   lclk_lvl;
  logic                   lclk_rise;
  rdburst_pkg::cmd_pkt_t  cmd_s1_r;
  rdburst_pkg::cmd_pkt_t  cmd_s2_r;
  rdburst_pkg::cmd_pkt_t  cmd_s3_r;
  rdburst_pkg::mode_t     mode_r;
  st_t                    st_r;
  logic [LAT_W-1:0]       lat_cnt_r;
  logic [3:0]             tail_cnt_r;
  logic                   chop_r;
  logic                   chop_nxt;
  logic [LAT_W-1:0]       rl;
  logic                   dq_oe_r;
  logic                   dqs_oe_r;
  logic                   dqs_r;
  logic [DQ_W-1:0]        dq_r;
  logic [9:0]             col_r;
  logic                   col_v_r;
  logic                   is_rd;
  logic                   burst_on;

  edge_sync u_lclk (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .async_in  (link_clk),
    .level_out (lclk_lvl),
    .rise_out  (lclk_rise)
  );

  // Command bus also comes from outside; delayed three stages to match the clock path
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_s1_r <= '0;
      cmd_s2_r <= '0;
      cmd_s3_r <= '0;
    end else begin
      cmd_s1_r <= cmd_in;
      cmd_s2_r <= cmd_s1_r;
      cmd_s3_r <= cmd_s2_r;
    end
  end

  assign is_rd = lclk_rise && (cmd_s3_r.op == rdburst_pkg::CMD_RD);
  assign rl    = LAT_W'(mode_r.al) + LAT_W'(mode_r.cl); // see R13
  assign burst_on = (st_r == ST_BURST);

  // Mode register load: bits 1:0 length mode, 7:4 CAS latency, 11:8 additive latency
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_r.bl_mode <= rdburst_pkg::BL_RESET;
      mode_r.cl      <= rdburst_pkg::CL_RESET;
      mode_r.al      <= rdburst_pkg::AL_RESET;
    end else if (lclk_rise && cmd_s3_r.op == rdburst_pkg::CMD_MRS) begin
      mode_r.bl_mode <= cmd_s3_r.addr[rdburst_pkg::BL_POS +: 2]; // see R3
      mode_r.cl      <= cmd_s3_r.addr[rdburst_pkg::CL_POS +: 4];
      mode_r.al      <= cmd_s3_r.addr[rdburst_pkg::AL_POS +: 4];
    end
  end

  // Burst length choice for the current command
  always_comb begin
    case (mode_r.bl_mode)
      rdburst_pkg::BL_FIXED8: chop_nxt = 1'b0; // see R16
      rdburst_pkg::BL_FIXED4: chop_nxt = 1'b1; // see R16
      rdburst_pkg::BL_OTF:    chop_nxt = !cmd_s3_r.addr[rdburst_pkg::CHOP_SEL]; // see R1
      default:                chop_nxt = 1'b0;
    endcase
  end

  // Read sequencer; a write or stray command never blocks it, so timing abuse cannot hang it
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= ST_IDLE;
    end else if (is_rd) begin
      st_r <= ST_WAIT; // A new read restarts the sequence; see R10 see R11
    end else if (lclk_rise) begin
      case (st_r)
        ST_IDLE: begin
          st_r <= ST_IDLE;
        end
        ST_WAIT: begin
          if (lat_cnt_r == '0) begin
            st_r <= ST_BURST; // see R13
          end
        end
        ST_BURST: begin
          if (tail_cnt_r == 4'h1) begin
            st_r <= ST_IDLE; // see R8
          end
        end
        default: begin
          st_r <= ST_IDLE;
        end
      endcase
    end
  end

  // Latency countdown in link cycles; holds at zero once the burst starts
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      lat_cnt_r <= '0;
    end else if (is_rd) begin
      lat_cnt_r <= rl - LAT_W'(1); // see R13
    end else if (lclk_rise && st_r == ST_WAIT && lat_cnt_r != '0) begin
      lat_cnt_r <= lat_cnt_r - LAT_W'(1);
    end
  end

  // Link cycles left in the drive window
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tail_cnt_r <= 4'h0;
    end else if (is_rd) begin
      tail_cnt_r <= chop_nxt ? rdburst_pkg::BC4_TAIL : rdburst_pkg::BL8_TAIL; // see R8
    end else if (lclk_rise && burst_on) begin
      tail_cnt_r <= tail_cnt_r - 4'h1;
    end
  end

  // Length of the read being served, kept until the next read
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      chop_r <= 1'b0;
    end else if (is_rd) begin
      chop_r <= chop_nxt; // see R1
    end
  end

  // One-cycle strobe for each read taken
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      col_v_r <= 1'b0;
    end else begin
      col_v_r <= is_rd;
    end
  end

  // Column capture; A12 is dropped from the column, only low ten bits form it
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      col_r <= 10'h000;
    end else if (is_rd) begin
      col_r <= cmd_s3_r.addr[9:0]; // see R2
    end
  end

  // Data drive window; pins read zero whenever the enable is low
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      dq_oe_r <= 1'b0;
      dq_r    <= '0;
    end else begin
      dq_oe_r <= burst_on; // see R8
      dq_r    <= burst_on ? rd_word : '0; // see R13
    end
  end

  // Strobe window: follows the link clock level while bursting
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      dqs_oe_r <= 1'b0;
      dqs_r    <= 1'b0;
    end else begin
      dqs_oe_r <= burst_on; // see R8
      dqs_r    <= burst_on && lclk_lvl;
    end
  end

  assign dq_oe       = dq_oe_r;
  assign dq_out      = dq_r;
  assign dqs_oe      = dqs_oe_r;
  assign dqs_out     = dqs_r;
  assign col_out     = col_r;
  assign col_valid   = col_v_r;
  assign chop_out    = chop_r;
  assign bl_mode_out = mode_r.bl_mode;
endmodule

// ### logic/rdburst_pkg.sv
// Purpose: Shared constants and types for the read burst engine
// Assumes: Command decode done outside; one command per link clock edge
// Notes:   Timing counts are in link clock cycles
package rdburst_pkg;
  localparam logic [1:0] BL_FIXED8   = 2'h0;
  localparam logic [1:0] BL_OTF      = 2'h1;
  localparam logic [1:0] BL_FIXED4   = 2'h2;
  localparam int         BL_POS      = 0;
  localparam int         CL_POS      = 4;
  localparam int         AL_POS      = 8;
  localparam logic [3:0] CL_RESET    = 4'h5;
  localparam logic [3:0] AL_RESET    = 4'h0;
  localparam logic [1:0] BL_RESET    = 2'h0;
  localparam logic [3:0] BL8_TAIL    = 4'h4;
  localparam logic [3:0] BC4_TAIL    = 4'h2;
  localparam int         CHOP_SEL    = 12;
  localparam int         DQ_W        = 8;
  localparam int         ADDR_W      = 16;

  typedef enum logic [2:0] {
    CMD_NOP = 3'h0,
    CMD_RD  = 3'h1,
    CMD_WR  = 3'h2,
    CMD_MRS = 3'h3
  } cmd_t;

  typedef struct packed {
    cmd_t              op;
    logic [ADDR_W-1:0] addr;
  } cmd_pkt_t;

  typedef struct packed {
    logic [1:0] bl_mode;
    logic [3:0] cl;
    logic [3:0] al;
  } mode_t;
endpackage

// ### test/ctrl_model.sv
// Purpose: Memory controller model driving link clock and commands
// Assumes: Commands change on the falling link edge
// Notes:   Link clock runs free, as a controller clock does
`timescale 1ns/1ps
module ctrl_model (
  output logic                  link_clk,
  output rdburst_pkg::cmd_pkt_t cmd_in
);
  real t_take;
  initial begin
    link_clk = 1'b0;
    cmd_in   = '0;
    // Offset keeps link edges and command changes off the ref_clk edges
    #1;
    forever #62.5 link_clk = ~link_clk;
  end
  // No bank traffic is sent and the engine ignores the writes that are, so spacing holds
  task automatic issue(input rdburst_pkg::cmd_t op, input logic [15:0] addr);
    @(negedge link_clk);
    cmd_in = {op, addr};
    @(posedge link_clk);
    t_take = $realtime;
    @(negedge link_clk);
    cmd_in = '0;
  endtask
endmodule

// ### test/rdburst_props.sv
// Purpose: Port checks for the read burst engine
// Assumes: Sees only the top ports
// Notes:   Burst lengths and latency are timed by the bench
`timescale 1ns/1ps
module rdburst_props #(
  parameter int DQ_W = rdburst_pkg::DQ_W
) (
  input wire logic                  ref_clk,
  input wire logic                  rst_n,
  input wire logic                  link_clk,
  input wire rdburst_pkg::cmd_pkt_t cmd_in,
  input wire logic [DQ_W-1:0]       rd_word,
  input wire logic                  dq_oe,
  input wire logic [DQ_W-1:0]       dq_out,
  input wire logic                  dqs_oe,
  input wire logic                  dqs_out,
  input wire logic [9:0]            col_out,
  input wire logic                  col_valid,
  input wire logic                  chop_out,
  input wire logic [1:0]            bl_mode_out
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  chk_oe_twin: assert property (dq_oe == dqs_oe)
    else $error("strobe and data enables differ");
  chk_dq_quiet: assert property (!dq_oe |-> dq_out == '0)
    else $error("data driven outside burst");
  chk_oe_hold: assert property ($rose(dq_oe) |-> dq_oe [*8])
    else $error("drive window too short");
  chk_col_once: assert property (col_valid |=> !col_valid)
    else $error("column strobe longer than one cycle");
  chk_fixed_eight: assert property
    (col_valid && bl_mode_out == rdburst_pkg::BL_FIXED8 |-> !chop_out)
    else $error("chop in fixed eight mode");
  chk_fixed_four: assert property
    (col_valid && bl_mode_out == rdburst_pkg::BL_FIXED4 |-> chop_out)
    else $error("no chop in fixed four mode");
  chk_dq_follow: assert property (dq_oe |-> dq_out == $past(rd_word))
    else $error("burst data differs from array word");
  chk_dqs_quiet: assert property (!dqs_oe |-> !dqs_out)
    else $error("strobe high outside burst");
endmodule
bind rdburst_engine rdburst_props #(.DQ_W(DQ_W)) props_u (.ref_clk(ref_clk), .rst_n(rst_n),
  .link_clk(link_clk), .cmd_in(cmd_in), .rd_word(rd_word), .dq_oe(dq_oe), .dq_out(dq_out),
  .dqs_oe(dqs_oe), .dqs_out(dqs_out), .col_out(col_out), .col_valid(col_valid),
  .chop_out(chop_out), .bl_mode_out(bl_mode_out));

// ### test/sdram_read_burst_precharge_timing_bench.sv
// Purpose: Random and corner read bursts across all length modes
// Assumes: Controller model owns link clock and commands
// Notes:   Burst timing is measured in link periods of 125 ns
`timescale 1ns/1ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin n_errors++; \
  $display("mismatch %s exp %0h got %0h", nm, e, g); end end
module sdram_read_burst_precharge_timing_bench;
  logic                           ref_clk;
  logic                           rst_n;
  logic                           link_clk;
  rdburst_pkg::cmd_pkt_t          cmd_in;
  logic [rdburst_pkg::DQ_W-1:0]   rd_word;
  logic [rdburst_pkg::DQ_W-1:0]   dq_out;
  logic                           dq_oe, dqs_oe, dqs_out, col_valid, chop_out;
  logic [9:0]                     col_out;
  logic [1:0]                     bl_mode_out;
  int                             n_errors, samples_checked, cycles;
  rdburst_engine dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .link_clk(link_clk),
    .cmd_in(cmd_in), .rd_word(rd_word), .dq_oe(dq_oe), .dq_out(dq_out), .dqs_oe(dqs_oe),
    .dqs_out(dqs_out), .col_out(col_out), .col_valid(col_valid), .chop_out(chop_out),
    .bl_mode_out(bl_mode_out));
  ctrl_model ctl_u (.link_clk(link_clk), .cmd_in(cmd_in));
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    rd_word <= #1 rdburst_pkg::DQ_W'($urandom);
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      stop_test();
    end
  end
  function automatic logic exp_chop(logic [1:0] m, logic a12);
    return m == rdburst_pkg::BL_FIXED4 || (m == rdburst_pkg::BL_OTF && !a12);
  endfunction
  task automatic rd_test(input logic [1:0] m, input logic a12);
    logic [3:0]  cl;
    logic [3:0]  al;
    logic [15:0] a;
    logic        ch;
    real         t1, t2;
    int          i;
    int          nr;
    logic        pv;
    cl = 4'h5 + 4'($urandom_range(3));
    al = 4'($urandom_range(3));
    a = 16'($urandom);
    a[12] = a12;
    ch = exp_chop(m, a12);
    ctl_u.issue(rdburst_pkg::CMD_MRS, {4'h0, al, cl, 2'h0, m});
    ctl_u.issue(rdburst_pkg::CMD_WR, a); // Must be ignored without hanging the read path
    ctl_u.issue(rdburst_pkg::CMD_RD, a);
    for (i = 0; i < 300 && dq_oe !== 1'b1; i++) @(negedge ref_clk);
    t1 = $realtime;
    pv = 1'b0;
    nr = 0;
    for (i = 0; i < 300 && dq_oe !== 1'b0; i++) begin
      if (dqs_out === 1'b1 && !pv) nr++;
      pv = (dqs_out === 1'b1);
      @(negedge ref_clk);
    end
    t2 = $realtime;
    `CHK("mode", m, bl_mode_out)
    `CHK("column", a[9:0], col_out)
    `CHK("chop", ch, chop_out)
    `CHK("latency", int'(al + cl), int'($floor((t1 - ctl_u.t_take) / 125.0)))
    `CHK("length", ch ? 2 : 4, int'((t2 - t1) / 125.0))
    `CHK("strobes", ch ? 2 : 4, nr)
    $display("test mode %0h a12 %0b done", m, a12);
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    rst_n = 1'b0;
    void'($urandom(57291));
    repeat (12) @(posedge ref_clk);
    #1 rst_n = 1'b1;
    // Every mode, including the spare code, with A12 low then high
    for (int k = 0; k < 8; k++) rd_test(2'(k), k[2]);
    // Reset in mid-run must bring mode and length back to their defaults
    @(posedge ref_clk);
    #1 rst_n = 1'b0;
    repeat (3) @(posedge ref_clk);
    #1;
    `CHK("mode after reset", rdburst_pkg::BL_RESET, bl_mode_out)
    `CHK("chop after reset", 1'b0, chop_out)
    `CHK("column after reset", 10'h000, col_out)
    rst_n = 1'b1;
    $display("test mid-run reset done");
    for (int k = 0; k < 8; k++) rd_test(2'($urandom_range(2)), 1'($urandom));
    stop_test();
  end
endmodule
